// ==== logic/lth_harness_map.vh ====
// Constants of the link test harness control block
`ifndef LTH_HARNESS_MAP_VH
`define LTH_HARNESS_MAP_VH
`define LTH_MODE_DUPLEX   2'h0
`define LTH_MODE_TX_ONLY  2'h1
`define LTH_MODE_RX_ONLY  2'h2
`define LTH_STYLE_PACKET  1'h1
`define LTH_STYLE_BURST   1'h0
`define LTH_SYNC_STAGES   3
`define LTH_PKT_COUNT     16'h0010
`define LTH_ST_IDLE       3'h0
`define LTH_ST_LOCK       3'h1
`define LTH_ST_ALIGN      3'h2
`define LTH_ST_RUN        3'h3
`define LTH_ST_DONE       3'h4
`define LTH_ST_RESTART    3'h5
`endif

// ==== logic/lth_harness_ctrl.v ====
// Control and status wrapper of the link test harness
`timescale 1ns/1ps
`include "lth_harness_map.vh"
module lth_harness_ctrl #(
    parameter [1:0]  MODE       = `LTH_MODE_DUPLEX,
    parameter        DATA_STYLE = `LTH_STYLE_PACKET,
    parameter [15:0] PKT_COUNT  = `LTH_PKT_COUNT
) (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        restartIn,
    input  wire        farEndAlignedIn,
    input  wire        txLaneLocked,
    input  wire        rxLaneLocked,
    input  wire        rxAligned,
    input  wire        txFifoError,
    input  wire        txPktSent,
    input  wire        rxPktRecv,
    input  wire        rxMismatch,
    output reg         coreReset,
    output reg         txEnable,
    output reg         rxEnable,
    output reg         trafficStyle,
    output reg         transmit_lane_locked_ind,
    output reg         receive_lane_locked_ind,
    output reg         rxAlignedInd,
    output reg         genDone,
    output reg         genFail,
    output reg         genBusy,
    output reg         monDone,
    output reg         monFail,
    output reg         monBusy
);
    localparam GEN_ON = (MODE != `LTH_MODE_RX_ONLY);
    localparam MON_ON = (MODE != `LTH_MODE_TX_ONLY);

    // ==========================================
    // Input three-stage registering
    // ==========================================
    reg [2:0] restartS_q;
    reg [2:0] farS_q;
    reg [2:0] txLockS_q;
    reg [2:0] rxLockS_q;
    reg [2:0] alignS_q;
    reg       restartPrev_q;
    reg       genBusyI_q;
    reg       monBusyI_q;
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            restartS_q    <= 3'h0;
            farS_q        <= 3'h0;
            txLockS_q     <= 3'h0;
            rxLockS_q     <= 3'h0;
            alignS_q      <= 3'h0;
            restartPrev_q <= 1'h0;
        end
        else
        begin
            restartS_q    <= {restartS_q[1:0], restartIn};
            farS_q        <= {farS_q[1:0], farEndAlignedIn};
            txLockS_q     <= {txLockS_q[1:0], txLaneLocked};
            rxLockS_q     <= {rxLockS_q[1:0], rxLaneLocked};
            alignS_q      <= {alignS_q[1:0], rxAligned};
            restartPrev_q <= restartS_q[2];
        end
    end
    wire restartPulse = restartS_q[2] & ~restartPrev_q;
    wire idleBoth     = ~genBusyI_q & ~monBusyI_q;
    wire startReq     = restartPulse & idleBoth;
    wire alignOk      = (MODE == `LTH_MODE_TX_ONLY) ? farS_q[2] : alignS_q[2];

    // ==========================================
    // Generator sequencer
    // ==========================================
    reg [2:0]  genSt_q;
    reg [15:0] genCnt_q;
    reg        genDoneI_q;
    reg        genFailI_q;
    always @(posedge ref_clk)
    begin
        if (rst || !GEN_ON)
        begin
            genSt_q    <= `LTH_ST_IDLE;
            genCnt_q   <= 16'h0000;
            genDoneI_q <= 1'h0;
            genFailI_q <= 1'h0;
            genBusyI_q <= 1'h0;
        end
        else
        begin
            if (txFifoError)
                genFailI_q <= 1'h1;
            case (genSt_q)
                `LTH_ST_IDLE:
                    if (startReq)
                    begin
                        genSt_q     <= `LTH_ST_LOCK;
                        genBusyI_q  <= 1'h1;
                        genDoneI_q  <= 1'h0;
                        // Fifo error in the same cycle wins over the clear
                        genFailI_q  <= txFifoError;
                        genCnt_q    <= 16'h0000;
                    end
                `LTH_ST_LOCK:
                    if (txLockS_q[2])
                        genSt_q <= `LTH_ST_ALIGN;
                `LTH_ST_ALIGN:
                    if (alignOk)
                        genSt_q <= `LTH_ST_RUN;
                `LTH_ST_RUN:
                    if (genCnt_q == PKT_COUNT)
                        genSt_q <= `LTH_ST_DONE;
                    else if (txPktSent)
                        genCnt_q <= genCnt_q + 16'h0001;
                `LTH_ST_DONE:
                begin
                    genDoneI_q <= 1'h1;
                    genSt_q    <= `LTH_ST_RESTART;
                end
                `LTH_ST_RESTART:
                begin
                    genBusyI_q  <= 1'h0;
                    genSt_q     <= `LTH_ST_IDLE;
                end
                default:
                    genSt_q <= `LTH_ST_IDLE;
            endcase
        end
    end

    // ==========================================
    // Monitor sequencer
    // ==========================================
    reg [2:0]  monSt_q;
    reg [15:0] monCnt_q;
    reg        monDoneI_q;
    reg        monErr_q;
    reg        monFailI_q;
    always @(posedge ref_clk)
    begin
        if (rst || !MON_ON)
        begin
            monSt_q     <= `LTH_ST_IDLE;
            monCnt_q    <= 16'h0000;
            monDoneI_q  <= 1'h0;
            monErr_q    <= 1'h0;
            monFailI_q  <= 1'h0;
            monBusyI_q  <= 1'h0;
        end
        else
        begin
            if (rxMismatch)
                monErr_q <= 1'h1;
            case (monSt_q)
                `LTH_ST_IDLE:
                    if (startReq)
                    begin
                        monSt_q     <= `LTH_ST_LOCK;
                        monBusyI_q  <= 1'h1;
                        monDoneI_q  <= 1'h0;
                        monCnt_q    <= 16'h0000;
                    end
                `LTH_ST_LOCK:
                    if (rxLockS_q[2])
                        monSt_q <= `LTH_ST_ALIGN;
                `LTH_ST_ALIGN:
                    if (alignS_q[2])
                        monSt_q <= `LTH_ST_RUN;
                `LTH_ST_RUN:
                    if (monCnt_q == PKT_COUNT)
                        monSt_q <= `LTH_ST_DONE;
                    else if (rxPktRecv)
                        monCnt_q <= monCnt_q + 16'h0001;
                `LTH_ST_DONE:
                begin
                    monDoneI_q <= 1'h1;
                    monFailI_q <= monErr_q | rxMismatch;
                    monSt_q    <= `LTH_ST_RESTART;
                end
                `LTH_ST_RESTART:
                begin
                    monBusyI_q  <= 1'h0;
                    monSt_q     <= `LTH_ST_IDLE;
                end
                default:
                    monSt_q <= `LTH_ST_IDLE;
            endcase
        end
    end

    // ==========================================
    // Output registering: status through three-stage chain plus one output register, coreReset/enables/style one register only
    // ==========================================
    reg [2:0] genBusyQ;
    reg [2:0] monBusyQ;
    reg [2:0] genDoneQ;
    reg [2:0] genFailQ;
    reg [2:0] monDoneQ;
    reg [2:0] monFailQ;
    reg [2:0] txLockQ;
    reg [2:0] rxLockQ;
    reg [2:0] alignQ;
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            genBusyQ <= 3'h0;
            monBusyQ <= 3'h0;
            genDoneQ <= 3'h0;
            genFailQ <= 3'h0;
            monDoneQ <= 3'h0;
            monFailQ <= 3'h0;
            txLockQ  <= 3'h0;
            rxLockQ  <= 3'h0;
            alignQ   <= 3'h0;
            coreReset    <= 1'h1;
            txEnable     <= 1'h0;
            rxEnable     <= 1'h0;
            trafficStyle <= DATA_STYLE[0];
            transmit_lane_locked_ind <= 1'h0;
            receive_lane_locked_ind  <= 1'h0;
            rxAlignedInd <= 1'h0;
            genDone <= 1'h0;
            genFail <= 1'h0;
            genBusy <= 1'h0;
            monDone <= 1'h0;
            monFail <= 1'h0;
            monBusy <= 1'h0;
        end
        else
        begin
            genBusyQ <= {genBusyQ[1:0], genBusyI_q};
            monBusyQ <= {monBusyQ[1:0], monBusyI_q};
            genDoneQ <= {genDoneQ[1:0], genDoneI_q};
            genFailQ <= {genFailQ[1:0], genFailI_q};
            monDoneQ <= {monDoneQ[1:0], monDoneI_q};
            monFailQ <= {monFailQ[1:0], monFailI_q};
            txLockQ  <= {txLockQ[1:0], GEN_ON & (MODE == `LTH_MODE_TX_ONLY) & txLockS_q[2]};
            rxLockQ  <= {rxLockQ[1:0], MON_ON & rxLockS_q[2]};
            alignQ   <= {alignQ[1:0], MON_ON & alignS_q[2]};
            coreReset    <= 1'h0;
            txEnable     <= GEN_ON & (genSt_q == `LTH_ST_RUN);
            rxEnable     <= MON_ON & (monSt_q != `LTH_ST_IDLE);
            trafficStyle <= DATA_STYLE[0];
            transmit_lane_locked_ind <= txLockQ[2];
            receive_lane_locked_ind  <= rxLockQ[2];
            rxAlignedInd <= alignQ[2];
            genDone <= genDoneQ[2];
            genFail <= genFailQ[2];
            genBusy <= genBusyQ[2];
            monDone <= monDoneQ[2];
            monFail <= monFailQ[2];
            monBusy <= monBusyQ[2];
        end
    end
endmodule

// ==== test/lth_link_model.sv ====
// Behavioural link core facing the harness control block
`timescale 1ns/1ps
module lth_link_model (
    input  wire ref_clk, txEnable, rxEnable, lockIn, pace, errInj,
    output reg  txLaneLocked = 1'b0, rxLaneLocked = 1'b0, rxAligned = 1'b0,
    output reg  txFifoError = 1'b0, txPktSent = 1'b0, rxPktRecv = 1'b0, rxMismatch = 1'b0
);
    // ==========================================
    // Lock, alignment and traffic pacing
    always @(posedge ref_clk)
    begin
        txLaneLocked <= lockIn;
        rxLaneLocked <= lockIn;
        rxAligned    <= rxLaneLocked;
        txPktSent    <= txEnable & pace;
        rxPktRecv    <= rxEnable & pace;
        txFifoError  <= txEnable & errInj;
        rxMismatch   <= rxEnable & errInj;
    end
endmodule

// ==== test/lth_harness_ctrl_sva.sv ====
// Checker of the harness control ports
`timescale 1ns/1ps
module lth_harness_ctrl_sva #(
    parameter [1:0]  MODE       = 2'h0,
    parameter        DATA_STYLE = 1'h1,
    parameter [15:0] PKT_COUNT  = 16'h0010
) (
    input wire ref_clk, rst, restartIn, txLaneLocked, rxAligned, txFifoError, txPktSent,
    input wire rxMismatch, coreReset, txEnable, rxEnable, trafficStyle, rxAlignedInd,
    input wire transmit_lane_locked_ind, genDone, genFail, genBusy, monDone, monFail, monBusy
);
    reg [4:0]  sinceRs_q;
    reg [15:0] pktCnt_q;
    reg        misSeen_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ==========================================
    // Helper counters
    always @(posedge ref_clk)
    begin
        if (rst)
            sinceRs_q <= 5'h1F;
        else
            sinceRs_q <= restartIn ? 5'h0 : sinceRs_q + {4'h0, sinceRs_q != 5'h1F};
        pktCnt_q  <= (rst || $fell(genBusy)) ? 16'h0 : pktCnt_q + {15'h0, txPktSent & txEnable};
        misSeen_q <= rst ? 1'b0 : misSeen_q | (rxMismatch & rxEnable);
    end
    // ==========================================
    // Properties
    AST_STYLE: assert property (trafficStyle == DATA_STYLE)
        else $error("traffic style differs from parameter");
    AST_RESET: assert property (disable iff (1'b0) rst |=> coreReset && !genBusy && !monBusy
        && !genDone && !genFail && !monDone && !monFail)
        else $error("indicators not cleared by reset");
    AST_START: assert property ($rose(genBusy) |-> sinceRs_q <= 5'h0E)
        else $error("generator started without restart");
    AST_DONE: assert property ($rose(genDone) |-> pktCnt_q >= PKT_COUNT)
        else $error("done before full packet count");
    AST_BUSYDROP: assert property ($fell(genBusy) |-> genDone)
        else $error("busy fell without done");
    AST_FAIL: assert property (txFifoError && txEnable |-> ##[1:8] genFail)
        else $error("fifo error not flagged");
    AST_ALIGN: assert property ((rxAligned && !$past(rst)) [*8] |->
        rxAlignedInd || MODE == 2'h1)
        else $error("alignment not shown");
    AST_SYNC: assert property (!rxAligned [*8] |-> !rxAlignedInd)
        else $error("alignment shown without cause");
    AST_TXLOCK: assert property ((txLaneLocked && !$past(rst)) [*8] |->
        transmit_lane_locked_ind || MODE != 2'h1)
        else $error("transmit lock not shown");
    AST_RXOFF: assert property (MODE != 2'h1 || (!monBusy && !rxEnable))
        else $error("monitor active in transmit-only");
    AST_TXOFF: assert property (MODE != 2'h2 || (!genBusy && !txEnable))
        else $error("generator active in receive-only");
    AST_DUPLEX: assert property ($rose(genBusy) && MODE == 2'h0 |-> ##[0:2] monBusy)
        else $error("monitor idle in duplex round");
    AST_STICKY: assert property ($rose(monDone) && misSeen_q |-> ##[0:2] monFail)
        else $error("mismatch not reported");
endmodule
bind lth_harness_ctrl lth_harness_ctrl_sva #(.MODE(MODE), .DATA_STYLE(DATA_STYLE),
    .PKT_COUNT(PKT_COUNT)) sva (.ref_clk(ref_clk), .rst(rst), .restartIn(restartIn),
    .txLaneLocked(txLaneLocked), .rxAligned(rxAligned), .txFifoError(txFifoError),
    .txPktSent(txPktSent), .rxMismatch(rxMismatch), .coreReset(coreReset),
    .txEnable(txEnable), .rxEnable(rxEnable), .trafficStyle(trafficStyle),
    .rxAlignedInd(rxAlignedInd), .transmit_lane_locked_ind(transmit_lane_locked_ind),
    .genDone(genDone), .genFail(genFail), .genBusy(genBusy), .monDone(monDone),
    .monFail(monFail), .monBusy(monBusy));

// ==== test/lth_harness_ctrl_bench.sv ====
// Self-checking bench of the harness control block, all three modes
`timescale 1ns/1ps
module lth_harness_ctrl_bench;
    reg ref_clk = 1'b0, rst = 1'b1, restartIn = 1'b0, farEnd = 1'b0;
    reg lockIn = 1'b0, pace = 1'b0, errInj = 1'b0;
    integer seed = 32'hA1E87A6F, err_count = 0, checked = 0, i, r;
    wire [2:0] gBusy, gDone, gFail, mBusy, mDone, mFail, tLock, rAl, sty, cRst, rLock;
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        r = $random(seed);
        pace <= r[0];
    end
    genvar m;
    generate for (m = 0; m < 3; m = m + 1)
    begin : g
        wire tE, rE, tL, rL, rA, tF, tP, rP, rM;
        lth_link_model core (.ref_clk(ref_clk), .txEnable(tE), .rxEnable(rE), .lockIn(lockIn),
            .pace(pace), .errInj(errInj), .txLaneLocked(tL), .rxLaneLocked(rL),
            .rxAligned(rA), .txFifoError(tF), .txPktSent(tP), .rxPktRecv(rP), .rxMismatch(rM));
        lth_harness_ctrl #(.MODE(2'(m)), .DATA_STYLE(m != 1), .PKT_COUNT(16'h0004)) uut (
            .ref_clk(ref_clk), .rst(rst), .restartIn(restartIn), .farEndAlignedIn(farEnd),
            .txLaneLocked(tL), .rxLaneLocked(rL), .rxAligned(rA), .txFifoError(tF),
            .txPktSent(tP), .rxPktRecv(rP), .rxMismatch(rM), .coreReset(cRst[m]), .txEnable(tE),
            .rxEnable(rE), .trafficStyle(sty[m]), .transmit_lane_locked_ind(tLock[m]),
            .receive_lane_locked_ind(rLock[m]), .rxAlignedInd(rAl[m]), .genDone(gDone[m]),
            .genFail(gFail[m]), .genBusy(gBusy[m]), .monDone(mDone[m]), .monFail(mFail[m]),
            .monBusy(mBusy[m]));
    end
    endgenerate
    // ==========================================
    // Tasks
    task chk(input [8*8:1] nm, input [2:0] exp, input [2:0] got);
    begin
        checked = checked + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("BAD %0s exp %b got %b", nm, exp, got);
        end
    end
    endtask
    task close_out;
    begin
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
    task restart;
    begin
        @(posedge ref_clk) restartIn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        restartIn <= 1'b0;
    end
    endtask
    task wait_done(input [8*8:1] nm);
    begin
        // Let busy rise first, so stale done flags are not taken
        repeat (10) @(posedge ref_clk);
        i = 0;
        while (i < 800 && ({gDone[1:0], mDone[2], mDone[0]} !== 4'hF || (gBusy | mBusy) !== 3'h0))
        begin
            @(posedge ref_clk); #1;
            i = i + 1;
        end
        if (i == 800)
        begin
            err_count = err_count + 1;
            $display("BAD %0s exp done got timeout", nm);
            close_out;
        end
        else
            $display("test %0s ended", nm);
    end
    endtask
    // ==========================================
    // Main sequence
    initial
    begin
        repeat (15) @(posedge ref_clk); #1;
        chk("corerst", 3'h7, cRst);
        @(posedge ref_clk) rst <= 1'b0;
        lockIn <= 1'b1;
        repeat (2) @(posedge ref_clk); #1;
        chk("clear", 3'h0, gBusy | mBusy | gDone | gFail | mDone | mFail | cRst);
        chk("style", 3'b101, sty);
        restart;
        repeat (40) @(posedge ref_clk); #1;
        chk("stall", 3'b100, {gBusy[1], gDone[1], 1'b0});
        restart;
        farEnd <= 1'b1;
        wait_done("first");
        chk("gdone", 3'b011, gDone);
        chk("mdone", 3'b101, mDone);
        chk("off", 3'h0, {gBusy[2] | gDone[2], mBusy[1] | mDone[1], 1'b0});
        chk("lock", 3'b010, tLock);
        chk("rlock", 3'b101, rLock);
        chk("align", 3'b011, {rAl[1], rAl[2], rAl[0]});
        repeat (20) @(posedge ref_clk); #1;
        chk("ignore", 3'h0, gBusy | mBusy);
        errInj <= 1'b1;
        restart;
        restart;
        wait_done("error");
        errInj <= 1'b0;
        chk("gfail", 3'b011, gFail);
        chk("mfail", 3'b101, mFail);
        restart;
        wait_done("clean");
        chk("gclear", 3'h0, gFail);
        chk("sticky", 3'b101, mFail);
        lockIn <= 1'b0;
        repeat (12) @(posedge ref_clk); #1;
        chk("unlock", 3'h0, rAl | tLock | rLock);
        $display("test unlock ended");
        lockIn <= 1'b1;
        restart;
        repeat (8 + r[2:0]) @(posedge ref_clk);
        rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk); #1;
        chk("reset", 3'h0, gBusy | mBusy | gDone | gFail | mDone | mFail | cRst);
        $display("test reset ended");
        close_out;
    end
endmodule
